// ---- hw/pin_sync.sv ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    // pins
    input  wire logic [W-1:0] pinIn,
    output logic [W-1:0]      pinOut
);
    if (W < 1) begin : g_bad_width
        $error("pin_sync needs at least one bit");
    end

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] held;
    } sync_s;

    sync_s q;
    sync_s d;
    logic [W-1:0] agree;

    // s1 is read by s2 alone; the filter looks only at s2 and s3
    always_comb begin
        agree = ~(q.s2 ^ q.s3);
        d = q;
        d.s1 = pinIn;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.held = (q.held & ~agree) | (q.s3 & agree);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= {RST, RST, RST, RST};
        end else begin
            q <= d;
        end
    end

    assign pinOut = q.held;
endmodule : pin_sync

// ---- hw/pll_cfg_pkg.sv ----
// shared constants for the pll synthesizer configuration port
// ============================================================
package pll_cfg_pkg;
    // ========================================
    // serial frame layout
    localparam int SHIFT_W = 14;
    localparam int POS_M   = 0;
    localparam int POS_N   = 9;
    localparam int POS_T   = 11;
    // ========================================
    // reset values
    localparam logic [8:0]  RST_LOOP   = 9'h1ff;
    localparam logic [1:0]  RST_OUTDIV = 2'h3;
    localparam logic [2:0]  RST_PROBE  = 3'h0;
    localparam logic [1:0]  RST_CTRL   = 2'h1;
    localparam logic [4:0]  RST_PULLDN = 5'h00;
    localparam logic [13:0] RST_PULLUP = 14'h3fff;
    // ========================================
    // apb map
    localparam logic [7:0] OFF_CONFIG = 8'h00;
    localparam logic [7:0] OFF_PINS   = 8'h04;
    localparam logic [7:0] OFF_CTRL   = 8'h08;
    localparam logic [7:0] OFF_SHIFT  = 8'h0c;
    localparam int CTRL_PROBE_EN = 0;
    localparam int CTRL_PAR_DIS  = 1;
    // ========================================
    // probe selections
    localparam logic [2:0] PROBE_REF   = 3'h0;
    localparam logic [2:0] PROBE_FB    = 3'h1;
    localparam logic [2:0] PROBE_SYNTH = 3'h2;
    localparam logic [2:0] PROBE_SHIFT = 3'h3;
    localparam logic [2:0] PROBE_VCO   = 3'h4;
    // vco half-cycles per output half-cycle, less one
    function automatic logic [2:0] divLimit(input logic [1:0] code);
        case (code)
            2'h0:    divLimit = 3'h1;
            2'h1:    divLimit = 3'h3;
            2'h2:    divLimit = 3'h7;
            default: divLimit = 3'h0;
        endcase
    endfunction : divLimit
endpackage : pll_cfg_pkg

// ---- hw/pll_synth_config_port.sv ----
// configuration logic of the pll synthesizer with apb status access
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
module pll_synth_config_port (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // serial configuration pins
    input  wire logic        sLoad,
    input  wire logic        sData,
    input  wire logic        sClock,
    // parallel configuration pins
    input  wire logic        pLoadN,
    input  wire logic [8:0]  loopDivIn,
    input  wire logic [1:0]  outDivIn,
    // output and reference control pins
    input  wire logic        outputGate,
    input  wire logic        ref_source_select,
    input  wire logic        crystalRef,
    input  wire logic        external_ref_in,
    // vco transitions, one pulse per vco half-cycle
    input  wire logic        vcoEdge,
    // outputs
    output logic             synth_clock_out,
    output logic             pllRefOut,
    output logic [8:0]       loopDivider,
    output logic [1:0]       outDivSelect,
    output logic             probeOut
);
    // ============================================================
    // state
    typedef struct packed {
        logic [pll_cfg_pkg::SHIFT_W-1:0] shiftReg;
        logic [8:0]                      loopDiv;
        logic [1:0]                      outDiv;
        logic [2:0]                      probeSel;
        logic [1:0]                      ctrl;
        logic                            sClkSeen;
        logic [8:0]                      fbCnt;
        logic                            fbOut;
        logic                            vcoPhase;
        logic                            refOut;
        logic                            probe;
        logic [31:0]                     rdata;
        logic                            slvErr;
    } port_s;

    port_s q;
    port_s d;

    // ============================================================
    // pin synchronisers
    logic [4:0]  lowPins;
    logic [13:0] highPins;
    logic        sLoadS;
    logic        sDataS;
    logic        sClkS;
    logic        xtalS;
    logic        extS;
    logic        pLoadNS;
    logic [8:0]  mS;
    logic [1:0]  nS;
    logic        gateS;
    logic        refSelS;
    logic        synthOut;

    // open pins settle to their pull level straight out of reset
    pin_sync #(
        .W   (5),
        .RST (pll_cfg_pkg::RST_PULLDN)
    ) u_sync_low (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pinIn    ({external_ref_in, crystalRef, sClock, sData, sLoad}),
        .pinOut   (lowPins)
    );

    pin_sync #(
        .W   (14),
        .RST (pll_cfg_pkg::RST_PULLUP)
    ) u_sync_high (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pinIn    ({ref_source_select, outputGate, outDivIn, loopDivIn, pLoadN}),
        .pinOut   (highPins)
    );

    assign sLoadS  = lowPins[0];
    assign sDataS  = lowPins[1];
    assign sClkS   = lowPins[2];
    assign xtalS   = lowPins[3];
    assign extS    = lowPins[4];
    assign pLoadNS = highPins[0];
    assign mS      = highPins[9:1];
    assign nS      = highPins[11:10];
    assign gateS   = highPins[12];
    assign refSelS = highPins[13];

    // ============================================================
    // next state
    logic [8:0] fbLimit;
    logic       apbSetup;
    logic       apbWrite;

    always_comb begin
        d = q;
        fbLimit = (q.loopDiv == 9'h000) ? 9'h000 : q.loopDiv - 9'h001;
        apbSetup = psel && !penable;
        apbWrite = psel && penable && pwrite;

        // serial shift register, first bit ends at the top of the frame
        d.sClkSeen = sClkS;
        if (sClkS && !q.sClkSeen) begin
            d.shiftReg = {q.shiftReg[pll_cfg_pkg::SHIFT_W-2:0], sDataS};
        end

        // parallel latches, meant for power-up; software may lock them out
        if (!pLoadNS && !q.ctrl[pll_cfg_pkg::CTRL_PAR_DIS]) begin
            d.loopDiv = mS;
            d.outDiv  = nS;
        end

        // serial latches win when both strobes are open; the hold on the
        // strobe fall relies on the controller keeping the frame steady
        if (sLoadS) begin
            d.loopDiv  = d.shiftReg[pll_cfg_pkg::POS_M +: 9];
            d.outDiv   = d.shiftReg[pll_cfg_pkg::POS_N +: 2];
            d.probeSel = d.shiftReg[pll_cfg_pkg::POS_T +: 3];
        end

        // feedback divider and vco phase for the probe
        if (vcoEdge) begin
            d.vcoPhase = !q.vcoPhase;
            if (q.fbCnt >= fbLimit) begin
                d.fbCnt = 9'h000;
                d.fbOut = !q.fbOut;
            end else begin
                d.fbCnt = q.fbCnt + 9'h001;
            end
        end

        // reference selection
        d.refOut = refSelS ? xtalS : extS;

        // probe selection
        case (q.probeSel)
            pll_cfg_pkg::PROBE_REF:   d.probe = q.refOut;
            pll_cfg_pkg::PROBE_FB:    d.probe = q.fbOut;
            pll_cfg_pkg::PROBE_SYNTH: d.probe = synthOut;
            pll_cfg_pkg::PROBE_SHIFT: d.probe = q.shiftReg[pll_cfg_pkg::SHIFT_W-1];
            pll_cfg_pkg::PROBE_VCO:   d.probe = q.vcoPhase;
            default:                  d.probe = 1'b0;
        endcase
        if (!q.ctrl[pll_cfg_pkg::CTRL_PROBE_EN]) begin
            d.probe = 1'b0;
        end

        // apb read data and error prepared in the setup cycle
        if (apbSetup) begin
            d.rdata  = 32'h0000_0000;
            d.slvErr = 1'b0;
            if (paddr == pll_cfg_pkg::OFF_CONFIG) begin
                d.slvErr = pwrite;
                d.rdata  = {18'h00000, q.probeSel, q.outDiv, q.loopDiv};
            end else if (paddr == pll_cfg_pkg::OFF_PINS) begin
                d.slvErr = pwrite;
                d.rdata  = {13'h0000, highPins, lowPins};
            end else if (paddr == pll_cfg_pkg::OFF_CTRL) begin
                d.rdata = {30'h00000000, q.ctrl};
            end else if (paddr == pll_cfg_pkg::OFF_SHIFT) begin
                d.slvErr = pwrite;
                d.rdata  = {18'h00000, q.shiftReg};
            end else begin
                d.slvErr = 1'b1;
            end
        end

        // write lands in the access cycle; pready is always high there
        if (apbWrite && paddr == pll_cfg_pkg::OFF_CTRL) begin
            d.ctrl = pwdata[1:0];
        end
    end

    // ============================================================
    // registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q          <= '0;
            q.loopDiv  <= pll_cfg_pkg::RST_LOOP;
            q.outDiv   <= pll_cfg_pkg::RST_OUTDIV;
            q.probeSel <= pll_cfg_pkg::RST_PROBE;
            q.ctrl     <= pll_cfg_pkg::RST_CTRL;
        end else begin
            q <= d;
        end
    end

    // ============================================================
    // output divider
    synth_divider u_div (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .vcoEdge  (vcoEdge),
        .divSel   (q.outDiv),
        .gateReq  (gateS),
        .clkOut   (synthOut)
    );

    assign synth_clock_out = synthOut;
    assign pllRefOut       = q.refOut;
    assign loopDivider     = q.loopDiv;
    assign outDivSelect    = q.outDiv;
    assign probeOut        = q.probe;
    assign pready          = penable;
    assign prdata          = q.rdata;
    assign pslverr         = q.slvErr;

    // ============================================================
    // assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    serialTransp_a: assert property (sLoadS |=>
        q.loopDiv == q.shiftReg[pll_cfg_pkg::POS_M +: 9]
        && q.probeSel == q.shiftReg[pll_cfg_pkg::POS_T +: 3])
        else $error("latches not following shift register");

    serialHold_a: assert property (!sLoadS && pLoadNS |=> $stable(q.loopDiv)
        && $stable(q.outDiv))
        else $error("latches changed with both strobes closed");

    parLoop_a: assert property (!sLoadS && !pLoadNS && !q.ctrl[1] |=>
        q.loopDiv == $past(mS))
        else $error("loop divider not following parallel pins");

    parOutDiv_a: assert property (!sLoadS && !pLoadNS && !q.ctrl[1] |=>
        q.outDiv == $past(nS))
        else $error("output divider not following parallel pins");

    shiftIn_a: assert property (sClkS && !q.sClkSeen |=>
        q.shiftReg == {$past(q.shiftReg[12:0]), $past(sDataS)})
        else $error("shift register missed a rising serial clock");

    shiftHold_a: assert property (!(sClkS && !q.sClkSeen) |=> $stable(q.shiftReg))
        else $error("shift register moved without a serial clock edge");

    probeSerial_a: assert property (!sLoadS |=> $stable(q.probeSel))
        else $error("probe selector changed outside the serial path");

    probeRoute_a: assert property (q.ctrl[0] && q.probeSel == 3'h2 |=>
        probeOut == $past(synthOut))
        else $error("probe not showing the synthesized clock");

    refPick_a: assert property (##1 pllRefOut == $past(refSelS ? xtalS : extS))
        else $error("wrong reference source");

    gateOff_a: assert property (!gateS [*3] |-> ##1 !$rose(synth_clock_out))
        else $error("output started a pulse while gated off");

    apbErr_a: assert property (psel && !penable && paddr == 8'h10 |=> pslverr)
        else $error("unmapped address not refused");

    serialLoad_c: cover property (sLoadS ##1 !sLoadS);
    parallelLoad_c: cover property (!pLoadNS ##1 pLoadNS);
    synthRise_c: cover property ($rose(synth_clock_out));
    ctrlWrite_c: cover property (psel && penable && pwrite && paddr == 8'h08);
endmodule : pll_synth_config_port

// ---- hw/synth_divider.sv ----
// output divider with glitch-free synchronous gate
`timescale 1ns/1ps
module synth_divider (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // vco and control
    input  wire logic       vcoEdge,
    input  wire logic [1:0] divSel,
    input  wire logic       gateReq,
    // synthesized clock
    output logic            clkOut
);
    typedef struct packed {
        logic [2:0] cnt;
        logic       phase;
        logic       out;
    } div_s;

    div_s       q;
    div_s       d;
    logic [2:0] limit;

    always_comb begin
        limit = pll_cfg_pkg::divLimit(divSel);
        d = q;
        if (vcoEdge) begin
            if (q.cnt >= limit) begin
                d.cnt = 3'h0;
                d.phase = !q.phase;
                // gate sampled only at a rising point, so pulses stay whole
                d.out = !q.phase && gateReq;
            end else begin
                d.cnt = q.cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign clkOut = q.out;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    divToggle_a: assert property (vcoEdge && q.cnt >= limit |=> q.phase != $past(q.phase))
        else $error("divider did not toggle at its limit");
    gateWhole_a: assert property ($rose(q.out) |-> $past(gateReq) && $past(vcoEdge))
        else $error("output rose without gate at a vco edge");
endmodule : synth_divider

// ---- testbench/cfg_ctrl_model.sv ----
// board controller model driving the serial and parallel configuration pins
`timescale 1ns/1ps
module cfg_ctrl_model (
    // clock
    input  wire logic core_clk,
    // serial pins
    output logic      sLoad,
    output logic      sData,
    output logic      sClock,
    // parallel pins
    output logic      pLoadN,
    output logic [8:0] loopDivIn,
    output logic [1:0] outDivIn
);
    // ========================================
    // idle lines rest at their pull levels
    initial begin
        sLoad = 1'b0;
        sData = 1'b0;
        sClock = 1'b0;
        pLoadN = 1'b1;
        loopDivIn = 9'h1ff;
        outDivIn = 2'h3;
    end
    task automatic waitClk(input int n);
        repeat (n) @(posedge core_clk);
    endtask : waitClk
    // ========================================
    // hold sets the pace: small is prompt, large is slow
    task automatic sendFrame(input logic [13:0] frame, input logic load, input int hold);
        for (int i = 13; i >= 0; i--) begin
            sData <= frame[i];
            waitClk(hold);
            sClock <= 1'b1;
            waitClk(hold);
            sClock <= 1'b0;
            waitClk(hold);
        end
        if (load) begin
            sLoad <= 1'b1;
            waitClk(hold + 2);
            sLoad <= 1'b0;
            waitClk(hold);
        end
        sData <= 1'b0; // released, pull-down
    endtask : sendFrame
    task automatic parLoad(input logic [8:0] m, input logic [1:0] n, input int hold);
        loopDivIn <= m;
        outDivIn <= n;
        waitClk(2);
        pLoadN <= 1'b0;
        waitClk(hold + 2);
        pLoadN <= 1'b1;
        waitClk(hold);
        loopDivIn <= 9'h1ff; // released, pull-up
        outDivIn <= 2'h3;
    endtask : parLoad
endmodule : cfg_ctrl_model

// ---- testbench/tb.sv ----
// self-checking bench for the pll configuration port
`timescale 1ns/1ps
module tb;
    logic        core_clk;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        sLoad;
    logic        sData;
    logic        sClock;
    logic        pLoadN;
    logic [8:0]  loopDivIn;
    logic [1:0]  outDivIn;
    logic        outputGate;
    logic        ref_source_select;
    logic        crystalRef;
    logic        external_ref_in;
    logic        vcoEdge;
    logic        synth_clock_out;
    logic        pllRefOut;
    logic [8:0]  loopDivider;
    logic [1:0]  outDivSelect;
    logic        probeOut;
    int          err_total;
    int          compares;
    int          expLoop;
    int          expN;
    int          expProbe;

    pll_synth_config_port pll_synth_config_port_inst (.core_clk(core_clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .sLoad(sLoad), .sData(sData),
        .sClock(sClock), .pLoadN(pLoadN), .loopDivIn(loopDivIn), .outDivIn(outDivIn),
        .outputGate(outputGate), .ref_source_select(ref_source_select),
        .crystalRef(crystalRef), .external_ref_in(external_ref_in), .vcoEdge(vcoEdge),
        .synth_clock_out(synth_clock_out), .pllRefOut(pllRefOut),
        .loopDivider(loopDivider), .outDivSelect(outDivSelect), .probeOut(probeOut));
    cfg_ctrl_model cfg_ctrl_model_inst (.core_clk(core_clk), .sLoad(sLoad), .sData(sData),
        .sClock(sClock), .pLoadN(pLoadN), .loopDivIn(loopDivIn), .outDivIn(outDivIn));

    always #2.5 core_clk = ~core_clk;

    // ========================================
    // bus and compare tasks
    task automatic waitClk(input int n);
        repeat (n) @(posedge core_clk);
    endtask : waitClk
    task automatic apbXfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                           output logic [31:0] rd, output logic err);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apbXfer
    task automatic chkPin(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t pin got %h want %h", $time, got, exp);
        end
    endtask : chkPin
    task automatic chkBus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          input logic [31:0] exp, input logic expErr);
        logic [31:0] rd;
        logic        e;
        apbXfer(wr, a, d, rd, e);
        compares++;
        if (e !== expErr || (!wr && rd !== exp)) begin
            err_total++;
            $display("[ERR] %0t bus %h got %h/%b want %h/%b", $time, a, rd, e, exp, expErr);
        end
    endtask : chkBus
    task automatic checkCfg;
        chkPin({23'h0, loopDivider}, 32'(expLoop));
        chkPin({30'h0, outDivSelect}, 32'(expN));
        chkBus(1'b0, pll_cfg_pkg::OFF_CONFIG, 32'h0,
               32'((expProbe << 11) | (expN << 9) | expLoop), 1'b0);
    endtask : checkCfg
    task automatic measureHalf(output int n);
        logic prev;
        int   guard;
        n = 0;
        guard = 0;
        prev = synth_clock_out;
        while (synth_clock_out === prev && guard < 40) begin
            @(posedge core_clk);
            guard++;
        end
        prev = synth_clock_out;
        while (synth_clock_out === prev && n < 40) begin
            @(posedge core_clk);
            n++;
        end
    endtask : measureHalf
    task automatic test_done;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    // ========================================
    // watchdog: the sequence needs about a thousand cycles
    initial begin
        #200000;
        err_total++;
        $display("[ERR] %0t watchdog expired", $time);
        test_done();
    end

    initial begin
        int          n;
        int          highs;
        int          ratio[4];
        logic [13:0] f;
        logic        s;
        logic        x;
        logic        e;
        ratio = '{2, 4, 8, 1};
        core_clk = 1'b0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        outputGate = 1'b1;
        ref_source_select = 1'b1;
        crystalRef = 1'b0;
        external_ref_in = 1'b0;
        vcoEdge = 1'b0;
        err_total = 0;
        compares = 0;
        expLoop = 511;
        expN = 3;
        expProbe = 0;
        void'($urandom(1));
        waitClk(12);
        rst_n <= 1'b1;
        waitClk(6);
        checkCfg();
        chkBus(1'b0, pll_cfg_pkg::OFF_PINS, 32'h0, 32'h0007ffe0, 1'b0);
        chkBus(1'b0, pll_cfg_pkg::OFF_CTRL, 32'h0, 32'h1, 1'b0);
        chkBus(1'b0, 8'h10, 32'h0, 32'h0, 1'b1);
        chkBus(1'b1, pll_cfg_pkg::OFF_CONFIG, 32'h5, 32'h0, 1'b1);
        // parallel load, then pins released to pull-ups must not disturb it
        expLoop = $urandom_range(511, 0);
        expN = $urandom_range(3, 0);
        cfg_ctrl_model_inst.parLoad(9'(expLoop), 2'(expN), 4);
        waitClk(6);
        checkCfg();
        // lockout: parallel path ignored
        chkBus(1'b1, pll_cfg_pkg::OFF_CTRL, 32'h3, 32'h0, 1'b0);
        chkBus(1'b0, pll_cfg_pkg::OFF_CTRL, 32'h0, 32'h3, 1'b0);
        cfg_ctrl_model_inst.parLoad(9'(~expLoop), 2'(~expN), 6);
        waitClk(6);
        checkCfg();
        chkBus(1'b1, pll_cfg_pkg::OFF_CTRL, 32'h1, 32'h0, 1'b0);
        // serial load with probe on shift bit 13, then shift without strobe
        f = {3'h3, 11'($urandom)};
        cfg_ctrl_model_inst.sendFrame(f, 1'b1, 4);
        expProbe = 3;
        expN = f[10:9];
        expLoop = f[8:0];
        waitClk(6);
        checkCfg();
        chkPin({31'h0, probeOut}, {31'h0, f[13]});
        f = {1'b1, 13'($urandom)};
        cfg_ctrl_model_inst.sendFrame(f, 1'b0, 6);
        waitClk(6);
        checkCfg();
        chkBus(1'b0, pll_cfg_pkg::OFF_SHIFT, 32'h0, {18'h0, f}, 1'b0);
        chkPin({31'h0, probeOut}, 32'h1);
        // output divider ratios
        for (int c = 0; c < 4; c++) begin
            expLoop = $urandom_range(511, 0);
            expN = c;
            cfg_ctrl_model_inst.parLoad(9'(expLoop), 2'(c), 4);
            waitClk(6);
            vcoEdge <= 1'b1;
            measureHalf(n);
            chkPin(32'(n), 32'(ratio[c]));
            vcoEdge <= 1'b0;
        end
        // gate low stops the output low, gate high resumes it
        vcoEdge <= 1'b1;
        outputGate <= 1'b0;
        waitClk(30);
        highs = 0;
        repeat (20) begin
            @(posedge core_clk);
            if (synth_clock_out !== 1'b0) highs++;
        end
        chkPin(32'(highs), 32'h0);
        outputGate <= 1'b1;
        measureHalf(n);
        chkPin(32'(n), 32'(ratio[3]));
        vcoEdge <= 1'b0;
        // probe on the synthesized clock, one cycle behind it
        f = {3'h2, 2'h1, 9'(expLoop)};
        cfg_ctrl_model_inst.sendFrame(f, 1'b1, 4);
        vcoEdge <= 1'b1;
        waitClk(8);
        repeat (16) begin
            s = synth_clock_out;
            @(posedge core_clk);
            chkPin({31'h0, probeOut}, {31'h0, s});
        end
        vcoEdge <= 1'b0;
        // reference selection
        repeat (6) begin
            s = 1'($urandom);
            x = 1'($urandom);
            e = 1'($urandom);
            ref_source_select <= s;
            crystalRef <= x;
            external_ref_in <= e;
            waitClk(8);
            chkPin({31'h0, pllRefOut}, {31'h0, (s ? x : e)});
        end
        test_done();
    end
endmodule : tb
